// ---- sat_timer.sv ----
// Saturating cycle counter used for the timeout, idle and stretch budgets.
// Assumes all inputs come from the same clock domain.
`timescale 1ns/1ps
`default_nettype none
module sat_timer (
  input  wire logic                                ref_clk_i,
  input  wire logic                                resetn_i,
  input  wire logic                                clr_i,    // Restart from zero, wins over run
  input  wire logic                                run_i,    // Count this cycle
  input  wire logic [smbus_timeout_pkg::TMR_W-1:0] limit_i,  // Saturation point
  output logic      [smbus_timeout_pkg::TMR_W-1:0] count_o,  // Cycles accumulated
  output logic                                     hit_o     // Count has reached the limit
);
  import smbus_timeout_pkg::*;

  // ==========================================================================
  // Counter
  // ==========================================================================
  logic [TMR_W-1:0] count_r;               // Accumulated cycles
  logic [TMR_W-1:0] count_nxt;             // Next count
  wire              full = (count_r >= limit_i);

  // Saturation keeps a long hold from wrapping back to a small count
  assign count_nxt = clr_i ? '0 : ((run_i && !full) ? count_r + 1'b1 : count_r);
  assign count_o   = count_r;
  assign hit_o     = full;

  // Plain register, reset to zero
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      count_r <= '0;
    end else begin
      count_r <= count_nxt;
    end
  end
endmodule
`default_nettype wire

// ---- smbus_host_model.sv ----
// Behavioural bus host that faces the timeout monitor.
// Assumes open-drain lines with pull-ups, resolved by the bench.
`timescale 1ns/1ps
`default_nettype none
module smbus_host_model (
  input  wire logic ref_clk_i,
  output logic      clk_oe_o,   // High pulls the clock line low
  output logic      data_oe_o   // High pulls the data line low
);
  // ==========================================================================
  // Line control
  // ==========================================================================
  localparam int HALF = 20;     // 80 ns half period of the link clock

  // Released at time zero, so both lines idle high
  initial begin
    clk_oe_o  = 1'b0;
    data_oe_o = 1'b0;
  end

  // Set both pulls, then hold them n core cycles; changes land just after an edge
  task automatic drive(input logic c, input logic d, input int n);
    clk_oe_o  = c;
    data_oe_o = d;
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask

  // Data falls while the clock is high, then the clock goes low
  task automatic send_start();
    drive(1'b0, 1'b0, HALF);
    drive(1'b0, 1'b1, HALF);
    drive(1'b1, 1'b1, HALF);
  endtask

  // Data changes only while the clock is low, so no stray start or stop;
  // the two low halves join across bits, giving a half-duty clock
  task automatic send_bit(input logic b);
    drive(1'b1, !b, HALF / 2);
    drive(1'b0, !b, HALF);
    drive(1'b1, !b, HALF / 2);
  endtask

  // Data rises while the clock is high
  task automatic send_stop();
    drive(1'b1, 1'b1, HALF);
    drive(1'b0, 1'b1, HALF);
    drive(1'b0, 1'b0, HALF);
  endtask
endmodule
`default_nettype wire

// ---- smbus_timeout_monitor.sv ----
// Timing and timeout supervision for the two-wire bus port.
// Assumes the pins arrive unsynchronised and the core drives its requests
// on ref_clk_i. Lines are open drain: output low, enable high to pull.
// Behaviour
// - Clock low past timeout aborts transaction
// - Both lines high 50 us resets transaction
// - Disable bit suppresses timeout and idle reset
// - Disable bit is bit 0, resets clear
// - Own slave stretching capped at 25 ms
// - Own master clock runs at 51.2 kHz
// - Fast mode 40-400 kHz, same supervision
`timescale 1ns/1ps
`default_nettype none
module smbus_timeout_monitor #(
  parameter int TIMEOUT_CYCLES = smbus_timeout_pkg::TIMEOUT_CYC,
  parameter int IDLE_CYCLES    = smbus_timeout_pkg::IDLE_CYC,
  parameter int SEXT_CYCLES    = smbus_timeout_pkg::SEXT_CYC
) (
  input  wire logic                         ref_clk_i,
  input  wire logic                         resetn_i,
  input  wire smbus_timeout_pkg::bus_pins_t pins_i,          // Line levels
  output logic                              bus_clock_pin_o, // Driven value
  output logic                              bus_data_pin_o,  // Driven value
  output smbus_timeout_pkg::bus_pins_t      pins_oe_o,       // Pull enables
  input  wire logic                         bus_timeout_disable_i, // Control bit 0
  input  wire logic                         master_en_i,     // Generate own clock
  input  wire logic                         stretch_req_i,   // Core wants a stretch
  input  wire logic                         data_low_req_i,  // Core pulls data low
  output logic                              txn_abort_o,     // One-cycle abort pulse
  output logic                              in_message_o,    // Between start and stop
  output logic                              stretch_spent_o  // Stretch budget used up
);
  import smbus_timeout_pkg::*;

  // ==========================================================================
  // Pin synchronisers and edge detection
  // ==========================================================================
  bus_pins_t sync1_r;                      // First stage, read only by sync2_r
  bus_pins_t sync2_r;                      // Safe level
  bus_pins_t prev_r;                       // Previous safe level

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sync1_r <= '1;
      sync2_r <= '1;
      prev_r  <= '1;
    end else begin
      sync1_r <= pins_i;
      sync2_r <= sync1_r;
      prev_r  <= sync2_r;
    end
  end

  // Start: data falls under a high clock; stop: data rises under it
  wire start_evt = prev_r.clk && sync2_r.clk && prev_r.data && !sync2_r.data;
  wire stop_evt  = prev_r.clk && sync2_r.clk && !prev_r.data && sync2_r.data;

  // ==========================================================================
  // Control bit
  // ==========================================================================
  logic timeout_dis_r;                     // Bit 0 of the clock control word

  // Caught after reset release, never during reset itself
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      timeout_dis_r <= TIMEOUT_DIS_RST;
    end else begin
      timeout_dis_r <= bus_timeout_disable_i;
    end
  end

  // ==========================================================================
  // Supervision timers
  // ==========================================================================
  msg_state_t       state_r;
  msg_state_t       state_nxt;
  logic [TMR_W-1:0] low_cnt;               // Current clock-low span
  logic [TMR_W-1:0] idle_cnt;              // Current both-high span
  logic [TMR_W-1:0] sext_cnt;              // Own stretch this message
  logic             low_hit;
  logic             idle_hit;
  logic             sext_hit;
  bus_pins_t        oe_r;                  // Pull enables
  logic             own_stretch;           // This cycle is own slave stretch

  // Supervision is independent of bus speed, so fast mode behaves alike
  wire low_run  = !sync2_r.clk && !timeout_dis_r;
  wire idle_run = sync2_r.clk && sync2_r.data && !timeout_dis_r;
  assign own_stretch = oe_r.clk && !master_en_i;

  sat_timer u_low (
    .ref_clk_i (ref_clk_i),
    .resetn_i  (resetn_i),
    .clr_i     (!low_run),
    .run_i     (low_run),
    .limit_i   (TMR_W'(TIMEOUT_CYCLES)),
    .count_o   (low_cnt),
    .hit_o     (low_hit)
  );

  sat_timer u_idle (
    .ref_clk_i (ref_clk_i),
    .resetn_i  (resetn_i),
    .clr_i     (!idle_run),
    .run_i     (idle_run),
    .limit_i   (TMR_W'(IDLE_CYCLES)),
    .count_o   (idle_cnt),
    .hit_o     (idle_hit)
  );

  // The stretch budget is cumulative over one message from its start
  sat_timer u_sext (
    .ref_clk_i (ref_clk_i),
    .resetn_i  (resetn_i),
    .clr_i     (start_evt),
    .run_i     (own_stretch),
    .limit_i   (TMR_W'(SEXT_CYCLES)),
    .count_o   (sext_cnt),
    .hit_o     (sext_hit)
  );

  // ==========================================================================
  // Message state
  // ==========================================================================
  wire in_msg = (state_r == ST_MSG);
  // Timers only run with detection enabled, so the disable bit gates both
  wire abort  = in_msg && (low_hit || idle_hit) && !timeout_dis_r;

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_WAIT: begin
        if (start_evt) begin
          state_nxt = ST_MSG;
        end
      end
      ST_MSG: begin
        // Abort or stop both fall back to waiting for a start
        if (abort || stop_evt) begin
          state_nxt = ST_WAIT;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_r <= ST_WAIT;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ==========================================================================
  // Master clock generator
  // ==========================================================================
  logic [HALF_W-1:0] half_r;               // Cycles in the current phase
  logic              mlow_r;               // Phase: 1 pulls the clock low
  logic              hold_r;               // Lines held released after abort

  // High phase only counts once the line is seen high, so a stretching
  // slave lengthens the period instead of being overridden
  wire half_done = (half_r == HALF_LAST);
  wire high_seen = !mlow_r && sync2_r.clk;
  wire mrun      = master_en_i && !hold_r;

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      half_r <= '0;
      mlow_r <= 1'b0;
    end else if (!mrun) begin
      half_r <= '0;
      mlow_r <= 1'b0;
    end else if (mlow_r || high_seen) begin
      half_r <= half_done ? '0 : half_r + 1'b1;
      mlow_r <= half_done ? !mlow_r : mlow_r;
    end
  end

  // ==========================================================================
  // Line drive and status outputs
  // ==========================================================================
  // Release hold lasts until the core drops every drive request
  wire any_req   = master_en_i || stretch_req_i || data_low_req_i;
  wire hold_nxt  = abort || (hold_r && any_req);
  // Last budget cycle in use now: stop before the count passes the budget
  wire sext_last = own_stretch && (sext_cnt == TMR_W'(SEXT_CYCLES - 1));
  wire slave_str = stretch_req_i && in_msg && !master_en_i && !sext_hit && !sext_last;
  bus_pins_t oe_nxt;

  // Stretch ends once the budget is spent, whatever the core asks
  assign oe_nxt.clk  = !hold_nxt && ((mrun && mlow_r) || slave_str);
  assign oe_nxt.data = !hold_nxt && data_low_req_i;

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      oe_r            <= '0;
      hold_r          <= 1'b0;
      bus_clock_pin_o <= 1'b0;
      bus_data_pin_o  <= 1'b0;
      txn_abort_o     <= 1'b0;
      in_message_o    <= 1'b0;
      stretch_spent_o <= 1'b0;
    end else begin
      oe_r            <= oe_nxt;
      hold_r          <= hold_nxt;
      bus_clock_pin_o <= 1'b0;             // Open drain only ever pulls low
      bus_data_pin_o  <= 1'b0;
      txn_abort_o     <= abort;
      in_message_o    <= (state_nxt == ST_MSG);
      stretch_spent_o <= sext_hit || sext_last;
    end
  end
  assign pins_oe_o = oe_r;

  // ==========================================================================
  // Assertions
  // ==========================================================================
  property p_low_abort;
    @(posedge ref_clk_i) disable iff (!resetn_i)
      (in_msg && low_run && low_cnt == TMR_W'(TIMEOUT_CYCLES))
      |=> (state_r == ST_WAIT) && txn_abort_o;
  endproperty
  a_low_abort: assert property (p_low_abort) else $error("clock low timeout missed");

  property p_idle_abort;
    @(posedge ref_clk_i) disable iff (!resetn_i)
      (in_msg && idle_run && idle_cnt == TMR_W'(IDLE_CYCLES))
      |=> (state_r == ST_WAIT) && txn_abort_o;
  endproperty
  a_idle_abort: assert property (p_idle_abort) else $error("idle reset missed");

  property p_disable;
    @(posedge ref_clk_i) disable iff (!resetn_i)
      timeout_dis_r |=> !txn_abort_o;
  endproperty
  a_disable: assert property (p_disable) else $error("abort while disabled");

  property p_reset_val;
    @(posedge ref_clk_i)
      (resetn_i && !$past(resetn_i)) |-> (timeout_dis_r == 1'b0);
  endproperty
  a_reset_val: assert property (p_reset_val) else $error("disable bit not clear");

  property p_stretch_cap;
    @(posedge ref_clk_i) disable iff (!resetn_i)
      (own_stretch && !start_evt) |-> (sext_cnt < TMR_W'(SEXT_CYCLES));
  endproperty
  a_stretch_cap: assert property (p_stretch_cap) else $error("stretch over budget");

  property p_master_half;
    @(posedge ref_clk_i) disable iff (!resetn_i)
      (mrun && $rose(mlow_r)) |-> mlow_r [*8] ##0 (half_r == HALF_W'(7));
  endproperty
  a_master_half: assert property (p_master_half) else $error("master low phase wrong");

  property p_stop_ends;
    @(posedge ref_clk_i) disable iff (!resetn_i)
      (in_msg && stop_evt) |=> (state_r == ST_WAIT) ##1 !in_message_o;
  endproperty
  a_stop_ends: assert property (p_stop_ends) else $error("stop not honoured");

  property p_release;
    @(posedge ref_clk_i) disable iff (!resetn_i)
      abort |=> (oe_r == '0) && (state_r == ST_WAIT);
  endproperty
  a_release: assert property (p_release) else $error("lines held after abort");
endmodule
`default_nettype wire

// ---- smbus_timeout_monitor_test.sv ----
// Self-checking bench for the bus timeout monitor.
// Assumes short counts set by parameter and a host model on the far side.
`timescale 1ns/1ps
`default_nettype none
module smbus_timeout_monitor_test;
  import smbus_timeout_pkg::*;
  // ==========================================================================
  // Signals
  // ==========================================================================
  localparam int TO_C = 200;   // Shortened clock-low timeout
  localparam int ID_C = 40;    // Shortened idle time
  localparam int SX_C = 100;   // Shortened stretch budget
  logic      ref_clk_i, resetn_i, dis, men, sreq, dreq;
  bus_pins_t pins, oe;
  logic      abort, inmsg, spent, h_c, h_d, bcp, bdp;
  logic [7:0] lfsr;           // Random source
  int        fail_count, checked, abort_cnt, n, base;
  wire logic [3:0] obs = {spent, inmsg, abort, oe.clk};
  // Open drain: a line is low while anyone pulls it
  assign pins = {!(h_c | oe.clk), !(h_d | oe.data)};

  smbus_timeout_monitor #(.TIMEOUT_CYCLES(TO_C), .IDLE_CYCLES(ID_C), .SEXT_CYCLES(SX_C)) dut_u (
    .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .pins_i(pins), .bus_clock_pin_o(bcp),
    .bus_data_pin_o(bdp), .pins_oe_o(oe), .bus_timeout_disable_i(dis), .master_en_i(men),
    .stretch_req_i(sreq), .data_low_req_i(dreq), .txn_abort_o(abort),
    .in_message_o(inmsg), .stretch_spent_o(spent));
  smbus_host_model host_u (.ref_clk_i(ref_clk_i), .clk_oe_o(h_c), .data_oe_o(h_d));

  // ==========================================================================
  // Helpers
  // ==========================================================================
  initial begin
    ref_clk_i = 1'b0;
    forever #2 ref_clk_i = ~ref_clk_i;
  end
  // Abort pulses are counted, so a missed or extra one shows up
  always @(posedge ref_clk_i) if (abort === 1'b1) abort_cnt++;

  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  // Bounded wait for one observed output to reach a level
  task automatic wait_bit(input int idx, input logic v, input int lim, output int cnt);
    cnt = 0;
    while (obs[idx] !== v && cnt < lim) begin
      @(posedge ref_clk_i);
      #1;
      cnt++;
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Watchdog: the tests need far fewer cycles than this
  initial begin
    #200000;
    fail_count++;
    print_verdict();
  end

  // ==========================================================================
  // Tests
  // ==========================================================================
  initial begin
    {dis, men, sreq, dreq, resetn_i} = 5'h00;
    {fail_count, checked, abort_cnt} = '0;
    lfsr = 8'h4E;
    repeat (10) @(posedge ref_clk_i);
    #1 resetn_i = 1'b1;
    check("reset outputs", 32'h0, {abort, inmsg, spent, oe});
    // Random message: bits and a core data pull must not end it
    host_u.send_start();
    wait_bit(2, 1'b1, 10, n);
    check("in message", 32'h1, inmsg);
    for (int i = 0; i < 12; i++) begin
      lfsr = lfsr_next(lfsr);
      host_u.send_bit(lfsr[0]);
    end
    dreq = 1'b1;
    host_u.drive(1'b1, 1'b1, 3);
    check("data pull", 32'h1, oe.data);
    dreq = 1'b0;
    host_u.send_stop();
    check("stop ends message", 32'h0, {abort_cnt[30:0], inmsg});
    $display("test done: random message");
    // Clock low timeout, aborts only after the window, with a request still up
    host_u.send_start();
    dreq = 1'b1;
    // The clock has already been low for the last 20 cycles of the start
    host_u.drive(1'b1, 1'b1, TO_C - 30);
    check("no early abort", 32'h0, abort_cnt);
    host_u.drive(1'b1, 1'b1, 30);
    check("timeout abort", 32'h1, abort_cnt);
    check("released after abort", 32'h0, {inmsg, oe});
    check("open drain levels", 32'h0, {bcp, bdp});
    dreq = 1'b0;
    host_u.send_stop();
    $display("test done: timeout");
    // Idle: both lines high inside a message
    host_u.send_start();
    host_u.send_bit(1'b1);
    host_u.drive(1'b1, 1'b0, 20);
    host_u.drive(1'b0, 1'b0, ID_C - 15);
    check("no early idle", 32'h1, abort_cnt);
    host_u.drive(1'b0, 1'b0, 30);
    check("idle abort", 32'h2, abort_cnt);
    check("await start", 32'h0, inmsg);
    $display("test done: idle");
    // Disabled supervision never aborts
    dis = 1'b1;
    host_u.send_start();
    host_u.drive(1'b1, 1'b1, 2 * TO_C);
    host_u.drive(1'b1, 1'b0, 20);
    host_u.drive(1'b0, 1'b0, 2 * ID_C);
    check("disabled no abort", 32'h5, {abort_cnt[1:0], inmsg});
    host_u.drive(1'b1, 1'b1, 20);
    host_u.send_stop();
    dis = 1'b0;
    $display("test done: disable");
    // Own stretch is cut at the budget
    host_u.send_start();
    host_u.drive(1'b0, 1'b1, 20);
    sreq = 1'b1;
    wait_bit(0, 1'b1, 5, n);
    check("stretch on", 32'h1, oe.clk);
    wait_bit(0, 1'b0, 2 * SX_C, n);
    check("stretch length", 32'h1, (n >= SX_C - 4) && (n <= SX_C));
    check("budget spent", 32'h1, spent);
    sreq = 1'b0;
    host_u.send_stop();
    host_u.send_start();
    check("budget cleared", 32'h0, spent);
    host_u.send_stop();
    $display("test done: stretch");
    // Own master clock high and low phases
    base = abort_cnt;
    men = 1'b1;
    // The first phase is high: it counts a full half period before pulling
    wait_bit(0, 1'b1, 3000, n);
    check("master high phase", 32'h1, (n >= MAS_HALF_CYC) && (n <= MAS_HALF_CYC + 3));
    wait_bit(0, 1'b0, 3000, n);
    check("master half period", 32'h1, (n >= MAS_HALF_CYC - 1) && (n <= MAS_HALF_CYC + 1));
    men = 1'b0;
    check("master no abort", base, abort_cnt);
    $display("test done: master");
    print_verdict();
  end
endmodule
`default_nettype wire

// ---- smbus_timeout_pkg.sv ----
// Shared constants and types for the bus timeout monitor.
// Assumes a 250 MHz core clock; all counts are derived from it here.
package smbus_timeout_pkg;

  // ==========================================================================
  // Clock and timing figures
  // ==========================================================================
  localparam int CLK_PERIOD_NS  = 4;       // Core clock period
  localparam int TIMEOUT_MIN_MS = 25;      // Clock-low timeout, least value used
  localparam int IDLE_MIN_US    = 50;      // Both lines high this long means idle
  localparam int SEXT_MAX_MS    = 25;      // Cumulative own stretch per message
  localparam int MAS_FREQ_HZ    = 51200;   // Own bus clock as master

  // Least times round up, longest times round down
  localparam int TIMEOUT_CYC = (TIMEOUT_MIN_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int IDLE_CYC    = (IDLE_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SEXT_CYC    = (SEXT_MAX_MS * 1000000) / CLK_PERIOD_NS;
  localparam int MAS_HALF_CYC = 1000000000 / (2 * MAS_FREQ_HZ * CLK_PERIOD_NS);

  // ==========================================================================
  // Widths and reset values
  // ==========================================================================
  localparam int TMR_W = 23;               // Holds counts up to 8.3 M cycles
  localparam int HALF_W = 12;              // Holds the master half period
  localparam logic [HALF_W-1:0] HALF_LAST = HALF_W'(MAS_HALF_CYC - 1);
  localparam logic TIMEOUT_DIS_RST = 1'b0; // Timeout detection on after reset

  // ==========================================================================
  // Types
  // ==========================================================================
  // The two bus lines travel together
  typedef struct packed {
    logic clk;
    logic data;
  } bus_pins_t;

  // Protocol state, one-hot
  typedef enum logic [1:0] {
    ST_WAIT = 2'b01,                       // Waiting for a start condition
    ST_MSG  = 2'b10                        // Inside a message
  } msg_state_t;

endpackage
